// >>> core/cpusq_regs.vh
/*
  Constants of the program sequencer: special register addresses, status
  bit positions, reset values and instruction field codes.
  Assumes inclusion by the sequencer files only; definitions only.
*/
`ifndef CPUSQ_REGS_VH
`define CPUSQ_REGS_VH
// Reset values
`define CPUSQ_PC_RESET 16'hFFF0
`define CPUSQ_STK_FILL 16'hFFFF
`define CPUSQ_STATUS_RESET 8'h00
`define CPUSQ_SP_RESET 12'hFFF
// Special register addresses
`define CPUSQ_A_SPH 12'h006
`define CPUSQ_A_SPL 12'h007
`define CPUSQ_A_PCL 12'h009
`define CPUSQ_A_STATUS 12'h00B
`define CPUSQ_A_DPH 12'h00C
`define CPUSQ_A_DPL 12'h00D
`define CPUSQ_A_RDH 12'h07C
`define CPUSQ_A_RDL 12'h07D
`define CPUSQ_A_RTH 12'h07E
`define CPUSQ_A_RTL 12'h07F
// Status bit positions
`define CPUSQ_ST_C 0
`define CPUSQ_ST_DC 1
`define CPUSQ_ST_Z 2
`define CPUSQ_ST_PAGE_HI 7
`define CPUSQ_ST_PAGE_LO 5
// Instruction groups, bits 15:12
`define CPUSQ_G_MISC 4'h0
`define CPUSQ_G_LOGIC 4'h1
`define CPUSQ_G_NOT 4'h2
`define CPUSQ_G_INCMOV 4'h3
`define CPUSQ_G_CSKIP 4'h4
`define CPUSQ_G_ADDC 4'h5
`define CPUSQ_G_IMM 4'h7
// Miscellaneous low-byte codes
`define CPUSQ_M_RET 8'h07
`define CPUSQ_M_PAGE 5'h02
`define CPUSQ_M_IREAD 8'h18
`define CPUSQ_M_IWRITE 8'h19
// Immediate-group codes, bits 11:8
`define CPUSQ_I_LOADH 4'h0
`define CPUSQ_I_LOADL 4'h1
`define CPUSQ_I_CMP 4'h9
`define CPUSQ_I_ADD 4'hB
`define CPUSQ_I_MOV 4'hC
`define CPUSQ_I_OR 4'hD
`define CPUSQ_I_AND 4'hE
`define CPUSQ_I_XOR 4'hF
// Arithmetic unit operations
`define CPUSQ_ALU_AND 4'h0
`define CPUSQ_ALU_OR 4'h1
`define CPUSQ_ALU_XOR 4'h2
`define CPUSQ_ALU_NOT 4'h3
`define CPUSQ_ALU_ADD 4'h4
`define CPUSQ_ALU_ADDC 4'h5
`define CPUSQ_ALU_SUB 4'h6
`define CPUSQ_ALU_INC 4'h7
`define CPUSQ_ALU_DEC 4'h8
`define CPUSQ_ALU_CLR 4'h9
`define CPUSQ_ALU_PASSA 4'hA
`define CPUSQ_ALU_PASSW 4'hB
`define CPUSQ_ALU_BSET 4'hC
`define CPUSQ_ALU_BCLR 4'hD
`endif

// >>> core/cpusq_alu.v
/*
  Byte arithmetic unit of the sequencer: logic, add and subtract, step,
  bit set and clear, with carry, digit carry and zero.
  Assumes purely combinational use inside the execute stage.
*/
`timescale 1ns/1ns
`include "cpusq_regs.vh"
module cpusq_alu (
  input wire [3:0] op,
  input wire [7:0] a,
  input wire [7:0] w,
  input wire cin,
  input wire [2:0] bsel,
  output reg [7:0] y,
  output reg c,
  output reg dc,
  output wire z
);
  reg [8:0] sum;
  reg [4:0] nib;
  reg [7:0] mask;

  // Subtraction is a - w, carry means no borrow
  always @* begin
    sum = 9'h000;
    nib = 5'h00;
    mask = 8'h01 << bsel;
    c = 1'b0;
    dc = 1'b0;
    case (op)
      `CPUSQ_ALU_AND: y = a & w;
      `CPUSQ_ALU_OR: y = a | w;
      `CPUSQ_ALU_XOR: y = a ^ w;
      `CPUSQ_ALU_NOT: y = ~a;
      `CPUSQ_ALU_ADD, `CPUSQ_ALU_ADDC, `CPUSQ_ALU_SUB: begin
        if (op == `CPUSQ_ALU_SUB) begin
          sum = {1'b0, a} + {1'b0, ~w} + 9'h001;
          nib = {1'b0, a[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
        end else begin
          sum = {1'b0, a} + {1'b0, w} + {8'h00, op == `CPUSQ_ALU_ADDC && cin};
          nib = {1'b0, a[3:0]} + {1'b0, w[3:0]} + {4'h0, op == `CPUSQ_ALU_ADDC && cin};
        end
        y = sum[7:0];
        c = sum[8];
        dc = nib[4];
      end
      `CPUSQ_ALU_INC: y = a + 8'h01;
      `CPUSQ_ALU_DEC: y = a - 8'h01;
      `CPUSQ_ALU_CLR: y = 8'h00;
      `CPUSQ_ALU_PASSW: y = w;
      `CPUSQ_ALU_BSET: y = a | mask;
      `CPUSQ_ALU_BCLR: y = a & ~mask;
      default: y = a;
    endcase
  end

  assign z = (y == 8'h00);
endmodule

// >>> core/cpusq_rstack.v
/*
  Hardware return-address stack, shifting levels held in flip-flops.
  Assumes one push, one pop or one top write per cycle at most.
*/
`timescale 1ns/1ns
`include "cpusq_regs.vh"
module cpusq_rstack #(
  parameter DEPTH = 16,
  parameter WIDTH = 16
) (
  input wire clock,
  input wire nrst,
  input wire ce,
  input wire push,
  input wire pop,
  input wire [WIDTH-1:0] push_data,
  input wire wr_hi,
  input wire wr_lo,
  input wire [7:0] wr_data,
  output wire [WIDTH-1:0] top
);
  reg [WIDTH-1:0] lvl_q [0:DEPTH-1];
  integer i;

  // Level 0 is the top; deeper levels shift as a whole
  always @(posedge clock) begin
    if (!nrst) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        lvl_q[i] <= `CPUSQ_STK_FILL;
      end
    end else if (ce) begin
      if (push) begin
        for (i = DEPTH - 1; i > 0; i = i - 1) begin
          lvl_q[i] <= lvl_q[i-1];
        end
        lvl_q[0] <= push_data;
      end else if (pop) begin
        for (i = 0; i < DEPTH - 1; i = i + 1) begin
          lvl_q[i] <= lvl_q[i+1];
        end
        lvl_q[DEPTH-1] <= `CPUSQ_STK_FILL;
      end else if (wr_hi) begin
        lvl_q[0][15:8] <= wr_data;
      end else if (wr_lo) begin
        lvl_q[0][7:0] <= wr_data;
      end
    end
  end

  assign top = lvl_q[0];
endmodule

// >>> core/cpusq_seq.v
/*
  Program sequencer of the byte core: fetch, decode, execute and write
  stages, skips, flushes on program counter change, page-extended jump
  and call targets, and the hardware return stack.
  Assumes program memory answers one cycle after its address, data
  memory reads combinationally from dm_raddr and writes on the clock
  edge while dm_we is high.
*/
`timescale 1ns/1ns
`include "cpusq_regs.vh"
module cpusq_seq #(
  parameter RS_DEPTH = 16
) (
  input wire clock,
  input wire nrst,
  input wire ce,
  output reg [15:0] pm_addr,
  input wire [15:0] pm_rdata,
  output reg [15:0] pm_data_addr,
  output reg pm_data_rd,
  output reg pm_data_wr,
  output reg [15:0] pm_data_wdata,
  input wire [15:0] pm_data_rdata,
  output reg [11:0] dm_raddr,
  input wire [7:0] dm_rdata,
  output reg dm_we,
  output reg [11:0] dm_waddr,
  output reg [7:0] dm_wdata,
  output reg [7:0] wreg,
  output reg [7:0] status,
  output reg skip_active,
  output reg retire
);
  // Pipeline state
  reg [15:0] dec_pc_q;
  reg dv_q;
  reg [15:0] ir_q;
  reg [15:0] ex_pc_q;
  reg ex_valid_q;
  reg rd_pend_q;
  // Architectural registers
  reg [11:0] sp_q;
  reg [7:0] dph_q;
  reg [7:0] dpl_q;
  reg [7:0] rdh_q;
  reg [7:0] rdl_q;
  // Execute-stage decisions
  reg [3:0] alu_op;
  reg [7:0] alu_w;
  reg wr_w, wr_fr, upd_c, upd_z, skip_take, branch, call_op, ret_op;
  reg push_op, pop_op, page_op, lh_op, ll_op, ird_op, iwr_op;
  reg [15:0] target;
  reg [11:0] wr_addr;
  reg [11:0] sp_d;
  reg [11:0] dec_addr;
  reg [7:0] opnd;
  wire [7:0] alu_y;
  wire alu_c, alu_dc, alu_z;
  wire [15:0] rs_top;
  wire [3:0] grp = ir_q[15:12];
  wire [1:0] sub = ir_q[11:10];
  wire dbit = ir_q[9];
  wire [11:0] fr_addr = {3'h0, ir_q[8:0]};
  wire [15:0] next_pc = ex_pc_q + 16'h0001;
  wire go = ex_valid_q && !skip_active;
  wire [11:0] ex_addr = dm_raddr;
  wire fwd = dm_we && (dm_waddr == ex_addr);
  wire is_ext_skip = (grp == `CPUSQ_G_IMM && ir_q[11:9] == 3'b000) ||
                     (grp == `CPUSQ_G_MISC && ir_q[11:8] == 4'h0 && ir_q[7:3] == `CPUSQ_M_PAGE);
  wire wr_sfr = (wr_addr == `CPUSQ_A_SPH) || (wr_addr == `CPUSQ_A_SPL) ||
                (wr_addr == `CPUSQ_A_PCL) || (wr_addr == `CPUSQ_A_STATUS) ||
                (wr_addr == `CPUSQ_A_DPH) || (wr_addr == `CPUSQ_A_DPL) ||
                (wr_addr == `CPUSQ_A_RDH) || (wr_addr == `CPUSQ_A_RDL) ||
                (wr_addr == `CPUSQ_A_RTH) || (wr_addr == `CPUSQ_A_RTL);

  // Operand fetch: special registers inside, memory outside with write forwarding
  always @* begin
    case (ex_addr)
      `CPUSQ_A_SPH: opnd = {4'h0, sp_q[11:8]};
      `CPUSQ_A_SPL: opnd = sp_q[7:0];
      `CPUSQ_A_PCL: opnd = next_pc[7:0];
      `CPUSQ_A_STATUS: opnd = status;
      `CPUSQ_A_DPH: opnd = dph_q;
      `CPUSQ_A_DPL: opnd = dpl_q;
      `CPUSQ_A_RDH: opnd = rdh_q;
      `CPUSQ_A_RDL: opnd = rdl_q;
      `CPUSQ_A_RTH: opnd = rs_top[15:8];
      `CPUSQ_A_RTL: opnd = rs_top[7:0];
      default: opnd = fwd ? dm_wdata : dm_rdata;
    endcase
  end

  cpusq_alu u_alu (
    .op(alu_op),
    .a((grp == `CPUSQ_G_IMM) ? ir_q[7:0] : opnd),
    .w(alu_w),
    .cin(status[`CPUSQ_ST_C]),
    .bsel(ir_q[11:9]),
    .y(alu_y),
    .c(alu_c),
    .dc(alu_dc),
    .z(alu_z)
  );

  // Instruction decode in execute; all effects gated by go
  always @* begin
    alu_op = `CPUSQ_ALU_PASSA;
    alu_w = wreg;
    wr_w = 1'b0;
    wr_fr = 1'b0;
    upd_c = 1'b0;
    upd_z = 1'b0;
    skip_take = 1'b0;
    call_op = 1'b0;
    ret_op = 1'b0;
    push_op = 1'b0;
    pop_op = 1'b0;
    page_op = 1'b0;
    lh_op = 1'b0;
    ll_op = 1'b0;
    ird_op = 1'b0;
    iwr_op = 1'b0;
    branch = 1'b0;
    target = {status[`CPUSQ_ST_PAGE_HI:`CPUSQ_ST_PAGE_LO], ir_q[12:0]};
    case (grp)
      `CPUSQ_G_MISC: begin
        if (sub == 2'b01) begin
          alu_op = dbit ? `CPUSQ_ALU_CLR : `CPUSQ_ALU_SUB;
          wr_fr = dbit;
          upd_c = !dbit;
          upd_z = 1'b1;
        end else if (ir_q[11:8] == 4'h0) begin
          ret_op = (ir_q[7:0] == `CPUSQ_M_RET);
          page_op = (ir_q[7:3] == `CPUSQ_M_PAGE);
          ird_op = (ir_q[7:0] == `CPUSQ_M_IREAD);
          iwr_op = (ir_q[7:0] == `CPUSQ_M_IWRITE);
        end
      end
      `CPUSQ_G_LOGIC: begin
        alu_op = (sub == 2'b00) ? `CPUSQ_ALU_OR : (sub == 2'b01) ? `CPUSQ_ALU_AND :
                 (sub == 2'b10) ? `CPUSQ_ALU_XOR : `CPUSQ_ALU_ADD;
        wr_w = !dbit;
        wr_fr = dbit;
        upd_c = (sub == 2'b11);
        upd_z = 1'b1;
      end
      `CPUSQ_G_NOT: begin
        alu_op = (sub == 2'b01) ? `CPUSQ_ALU_NOT : `CPUSQ_ALU_SUB;
        wr_w = !dbit;
        wr_fr = dbit;
        upd_c = (sub != 2'b01);
        upd_z = 1'b1;
      end
      `CPUSQ_G_INCMOV: begin
        if (sub[1] == 1'b0) begin
          alu_op = sub[0] ? `CPUSQ_ALU_DEC : `CPUSQ_ALU_INC;
          wr_w = !dbit;
          wr_fr = dbit;
          skip_take = alu_z;
        end else if (sub == 2'b10) begin
          alu_op = dbit ? `CPUSQ_ALU_PASSW : `CPUSQ_ALU_PASSA;
          wr_w = !dbit;
          wr_fr = dbit;
          upd_z = 1'b1;
        end else begin
          push_op = !dbit;
          pop_op = dbit;
          wr_fr = 1'b1;
        end
      end
      `CPUSQ_G_CSKIP: begin
        alu_op = `CPUSQ_ALU_SUB;
        skip_take = (sub == 2'b00) && (alu_z == dbit);
      end
      `CPUSQ_G_ADDC: begin
        alu_op = (sub == 2'b11) ? `CPUSQ_ALU_ADDC : `CPUSQ_ALU_SUB;
        wr_w = !dbit;
        wr_fr = dbit;
        upd_c = 1'b1;
        upd_z = 1'b1;
      end
      `CPUSQ_G_IMM: begin
        lh_op = (ir_q[11:8] == `CPUSQ_I_LOADH);
        ll_op = (ir_q[11:8] == `CPUSQ_I_LOADL);
        case (ir_q[11:8])
          `CPUSQ_I_CMP: alu_op = `CPUSQ_ALU_SUB;
          `CPUSQ_I_ADD: alu_op = `CPUSQ_ALU_ADD;
          `CPUSQ_I_OR: alu_op = `CPUSQ_ALU_OR;
          `CPUSQ_I_AND: alu_op = `CPUSQ_ALU_AND;
          `CPUSQ_I_XOR: alu_op = `CPUSQ_ALU_XOR;
          default: alu_op = `CPUSQ_ALU_PASSA;
        endcase
        wr_w = !lh_op && !ll_op && (ir_q[11:8] != `CPUSQ_I_CMP);
        upd_c = (ir_q[11:8] == `CPUSQ_I_CMP) || (ir_q[11:8] == `CPUSQ_I_ADD);
        upd_z = wr_w || upd_c;
      end
      4'h8, 4'h9: begin
        alu_op = grp[0] ? `CPUSQ_ALU_BSET : `CPUSQ_ALU_BCLR;
        wr_fr = 1'b1;
      end
      4'hA, 4'hB: begin
        skip_take = (opnd[ir_q[11:9]] == !grp[0]);
      end
      default: begin
        call_op = ir_q[13];
        branch = 1'b1;
      end
    endcase
    if (ret_op) begin
      branch = 1'b1;
      target = rs_top;
    end
    wr_addr = pop_op ? fr_addr : push_op ? sp_q : ex_addr;
    if (wr_fr && wr_addr == `CPUSQ_A_PCL) begin
      branch = 1'b1;
      target = {next_pc[15:8], alu_y};
    end
    if (push_op || pop_op) begin
      alu_op = `CPUSQ_ALU_PASSA;
      alu_w = opnd;
    end
    // Stack pointer as it will stand after this instruction
    sp_d = sp_q;
    if (go && push_op) begin
      sp_d = sp_q - 12'h001;
    end else if (go && pop_op) begin
      sp_d = sp_q + 12'h001;
    end else if (go && wr_fr && wr_addr == `CPUSQ_A_SPH) begin
      sp_d = {alu_y[3:0], sp_q[7:0]};
    end else if (go && wr_fr && wr_addr == `CPUSQ_A_SPL) begin
      sp_d = {sp_q[11:8], alu_y};
    end
  end

  // Operand address for the word now in decode; pop reads the new stack top
  always @* begin
    if (pm_rdata[15:9] == {`CPUSQ_G_INCMOV, 2'b11, 1'b1}) begin
      dec_addr = sp_d + 12'h001;
    end else begin
      dec_addr = {3'h0, pm_rdata[8:0]};
    end
  end

  cpusq_rstack #(
    .DEPTH(RS_DEPTH),
    .WIDTH(16)
  ) u_rstack (
    .clock(clock),
    .nrst(nrst),
    .ce(ce),
    .push(go && call_op),
    .pop(go && ret_op),
    .push_data(next_pc),
    .wr_hi(go && wr_fr && wr_addr == `CPUSQ_A_RTH),
    .wr_lo(go && wr_fr && wr_addr == `CPUSQ_A_RTL),
    .wr_data(alu_y),
    .top(rs_top)
  );

  // Fetch and decode stages, flushed when the program counter is redirected
  always @(posedge clock) begin
    if (!nrst) begin
      pm_addr <= `CPUSQ_PC_RESET;
      dec_pc_q <= `CPUSQ_PC_RESET;
      dv_q <= 1'b0;
      ir_q <= 16'h0000;
      ex_pc_q <= 16'h0000;
      ex_valid_q <= 1'b0;
      dm_raddr <= 12'h000;
    end else if (ce) begin
      if (go && branch) begin
        pm_addr <= target;
        dv_q <= 1'b0;
        ex_valid_q <= 1'b0;
      end else begin
        pm_addr <= pm_addr + 16'h0001;
        dec_pc_q <= pm_addr;
        dv_q <= 1'b1;
        ir_q <= pm_rdata;
        ex_pc_q <= dec_pc_q;
        ex_valid_q <= dv_q;
        dm_raddr <= dec_addr;
      end
    end
  end

  // Skip state lives in one flag, so a sequence can be broken between cycles
  always @(posedge clock) begin
    if (!nrst) begin
      skip_active <= 1'b0;
      retire <= 1'b0;
    end else if (ce) begin
      retire <= go;
      if (go && branch) begin
        skip_active <= 1'b0;
      end else if (go) begin
        skip_active <= skip_take;
      end else if (ex_valid_q && skip_active) begin
        skip_active <= is_ext_skip;
      end
    end
  end

  // Execute results: W, status, pointers; annulled slots change nothing
  always @(posedge clock) begin
    if (!nrst) begin
      wreg <= 8'h00;
      status <= `CPUSQ_STATUS_RESET;
      sp_q <= `CPUSQ_SP_RESET;
      dph_q <= 8'h00;
      dpl_q <= 8'h00;
    end else if (ce) begin
      sp_q <= sp_d;
      if (go) begin
        if (wr_w) begin
          wreg <= alu_y;
        end
        if (wr_fr && wr_addr == `CPUSQ_A_STATUS) begin
          status <= alu_y;
        end else begin
          if (upd_c) begin
            status[`CPUSQ_ST_C] <= alu_c;
            status[`CPUSQ_ST_DC] <= alu_dc;
          end
          if (upd_z) begin
            status[`CPUSQ_ST_Z] <= alu_z;
          end
          if (page_op) begin
            status[`CPUSQ_ST_PAGE_HI:`CPUSQ_ST_PAGE_LO] <= ir_q[2:0];
          end
        end
        if (lh_op || (wr_fr && wr_addr == `CPUSQ_A_DPH)) begin
          dph_q <= alu_y;
        end
        if (ll_op || (wr_fr && wr_addr == `CPUSQ_A_DPL)) begin
          dpl_q <= alu_y;
        end
      end
    end
  end

  // Write stage: memory result lands one cycle after execute
  always @(posedge clock) begin
    if (!nrst) begin
      dm_we <= 1'b0;
      dm_waddr <= 12'h000;
      dm_wdata <= 8'h00;
    end else if (ce) begin
      dm_we <= go && wr_fr && !wr_sfr;
      dm_waddr <= wr_addr;
      dm_wdata <= alu_y;
    end
  end

  // Program memory data port; read word lands in the read-data pair
  always @(posedge clock) begin
    if (!nrst) begin
      pm_data_addr <= 16'h0000;
      pm_data_rd <= 1'b0;
      pm_data_wr <= 1'b0;
      pm_data_wdata <= 16'h0000;
      rd_pend_q <= 1'b0;
      rdh_q <= 8'h00;
      rdl_q <= 8'h00;
    end else if (ce) begin
      pm_data_rd <= go && ird_op;
      pm_data_wr <= go && iwr_op;
      rd_pend_q <= pm_data_rd;
      if (go && (ird_op || iwr_op)) begin
        pm_data_addr <= {dph_q, dpl_q};
        pm_data_wdata <= {rdh_q, rdl_q};
      end
      if (rd_pend_q) begin
        rdh_q <= pm_data_rdata[15:8];
        rdl_q <= pm_data_rdata[7:0];
      end else if (go && wr_fr && wr_addr == `CPUSQ_A_RDH) begin
        rdh_q <= alu_y;
      end else if (go && wr_fr && wr_addr == `CPUSQ_A_RDL) begin
        rdl_q <= alu_y;
      end
    end
  end
endmodule

// >>> verification/cpusq_seq_asserts.sv
/*
  Port checker of the program sequencer: flush timing, pipeline fill,
  annulled slots and write protection of the PCL, RTH and RTL addresses.
  Assumes it is bound to cpusq_seq; any attempt that overlaps a clock
  enable pause is dropped, since every flop of the design is frozen then.
*/
`timescale 1ns/1ns
module cpusq_seq_asserts #(
  parameter RS_DEPTH = 16
) (
  input wire clock,
  input wire nrst,
  input wire ce,
  input wire [15:0] pm_addr,
  input wire pm_data_rd,
  input wire pm_data_wr,
  input wire dm_we,
  input wire [11:0] dm_waddr,
  input wire skip_active,
  input wire retire
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst || !ce);
  reg [15:0] prev_pc_q;
  reg live_q;
  wire redirect;
  wire special_addr = (dm_waddr == 12'h009) || (dm_waddr == 12'h07E) || (dm_waddr == 12'h07F);
  // Last fetch address; a jump breaks the plus-one walk, a pause would fake one
  always @(posedge clock) begin
    prev_pc_q <= pm_addr;
    live_q <= nrst && ce;
  end
  assign redirect = live_q && ce && (pm_addr != prev_pc_q + 16'h0001);
  // Two dead slots, then the target executes
  sequence refill_s;
    !retire [*2] ##1 retire;
  endsequence
  sequence seq_walk_s;
    !redirect [*2];
  endsequence
  AST_FLUSH_THREE: assert property (redirect |-> retire ##1 refill_s)
    else $error("branch did not take three cycles");
  AST_FETCH_STEP: assert property (redirect |=> seq_walk_s)
    else $error("refill did not fetch sequentially");
  AST_FILL: assert property ($rose(nrst) |-> !retire ##1 !retire)
    else $error("instruction retired before pipeline filled");
  AST_SKIP_NO_WRITE: assert property (skip_active |=> !dm_we)
    else $error("annulled instruction wrote data memory");
  AST_SKIP_NO_RETIRE: assert property (skip_active |=> !retire)
    else $error("annulled instruction retired");
  AST_SKIP_CAUSE: assert property ($rose(skip_active) |-> retire)
    else $error("annul started without a retiring test");
  AST_SPECIAL_NO_WE: assert property (dm_we |-> !special_addr)
    else $error("data memory write to special address");
  AST_PM_READ_PULSE: assert property (pm_data_rd |-> !pm_data_wr ##1 !pm_data_rd)
    else $error("program read request not a lone pulse");
endmodule
bind cpusq_seq cpusq_seq_asserts #(.RS_DEPTH(RS_DEPTH)) u_chk (.clock(clock), .nrst(nrst), .ce(ce),
  .pm_addr(pm_addr), .pm_data_rd(pm_data_rd), .pm_data_wr(pm_data_wr), .dm_we(dm_we),
  .dm_waddr(dm_waddr), .skip_active(skip_active), .retire(retire));

// >>> verification/cpusq_mem_model.sv
/*
  Program memory and data memory beside the sequencer.
  Assumes the bench loads the program array after time zero and that the
  memories share the core's clock enable.
*/
`timescale 1ns/1ns
module cpusq_mem_model (
  input wire clock,
  input wire ce,
  input wire [15:0] pm_addr,
  output logic [15:0] pm_rdata,
  input wire [15:0] pm_data_addr,
  input wire pm_data_rd,
  input wire pm_data_wr,
  input wire [15:0] pm_data_wdata,
  output logic [15:0] pm_data_rdata,
  input wire [11:0] dm_raddr,
  output wire [7:0] dm_rdata,
  input wire dm_we,
  input wire [11:0] dm_waddr,
  input wire [7:0] dm_wdata
);
  logic [15:0] pm [0:65535];
  logic [7:0] dm [0:4095];
  // Blank memories so stray fetches decode as known words
  initial begin
    pm_rdata = 16'h0000;
    pm_data_rdata = 16'h0000;
    for (int i = 0; i < 65536; i++) pm[i] = 16'h0000;
    for (int i = 0; i < 4096; i++) dm[i] = 8'h00;
    // Underflow catch: jumps to the reset vector once page bits are 7
    pm[16'hFFFF] = 16'hDFF0;
  end
  assign dm_rdata = dm[dm_raddr];
  // Fetch one cycle late; a pause must hold the answer or a word is lost
  always @(posedge clock) begin
    if (ce) begin
      pm_rdata <= pm[pm_addr];
      if (dm_we) dm[dm_waddr] <= dm_wdata;
      if (pm_data_wr) pm[pm_data_addr] <= pm_data_wdata;
      pm_data_rdata <= pm_data_rd ? pm[pm_data_addr] : ~pm_data_rdata; // Stale data toggles
    end
  end
endmodule

// >>> verification/cpusq_seq_tb.sv
/*
  Self-checking bench: runs a short program through the sequencer and
  compares memory writes, registers and control flow.
  Assumes the memory model and the bound checker.
*/
`timescale 1ns/1ns
module cpusq_seq_tb;
  logic clock, nrst, ce;
  wire [15:0] pm_addr, pm_rdata, pm_data_addr, pm_data_wdata, pm_data_rdata;
  wire pm_data_rd, pm_data_wr, dm_we, skip_active, retire;
  wire [11:0] dm_raddr, dm_waddr;
  wire [7:0] dm_rdata, dm_wdata, wreg, status;
  int err_count = 0;
  int check_count = 0;
  int n;
  logic [19:0] wr_q [$];
  logic [15:0] rd_addr = 16'h0000;
  logic z_hold = 0, annul_w = 0, page3 = 0, in_sub = 0, back = 0, far = 0, got_rd = 0, rel_jmp = 0;
  logic [15:0] pc_hold;
  // Address and word pairs of the program
  logic [31:0] prog [26] = '{32'hFFF0C010, 32'h00107C5A, 32'h00113AA0, 32'h001290A0, 32'h00138CA0,
    32'h001418A0, 32'h00157941, 32'h001636A0, 32'h0017A2A0, 32'h00180013, 32'h00197CEE,
    32'h001AE040, 32'h001B7012, 32'h001C7134, 32'h001D0018, 32'h001E0011, 32'h001F7C77,
    32'h0020387C, 32'h0021C005, 32'h0040387F, 32'h00413AA1, 32'h00420007, 32'h20057C99,
    32'h20061E09, 32'h20A0C0A0, 32'h1234BEEF};
  logic [19:0] exp_w [5] = '{20'h0A05A, 20'h0A05B, 20'h0A01B, 20'h0A01A, 20'h0A11B};
  cpusq_mem_model mem (.clock(clock), .ce(ce), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
    .pm_data_addr(pm_data_addr), .pm_data_rd(pm_data_rd), .pm_data_wr(pm_data_wr),
    .pm_data_wdata(pm_data_wdata), .pm_data_rdata(pm_data_rdata), .dm_raddr(dm_raddr),
    .dm_rdata(dm_rdata), .dm_we(dm_we), .dm_waddr(dm_waddr), .dm_wdata(dm_wdata));
  cpusq_seq #(.RS_DEPTH(16)) dut (.clock(clock), .nrst(nrst), .ce(ce), .pm_addr(pm_addr),
    .pm_rdata(pm_rdata), .pm_data_addr(pm_data_addr), .pm_data_rd(pm_data_rd),
    .pm_data_wr(pm_data_wr), .pm_data_wdata(pm_data_wdata), .pm_data_rdata(pm_data_rdata),
    .dm_raddr(dm_raddr), .dm_rdata(dm_rdata), .dm_we(dm_we), .dm_waddr(dm_waddr),
    .dm_wdata(dm_wdata), .wreg(wreg), .status(status), .skip_active(skip_active), .retire(retire));
  task automatic check(input string name, input logic [19:0] exp, input logic [19:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Event log: writes, read address and flow landmarks
  always @(posedge clock) begin
    if (nrst === 1'b1) begin
      if (dm_we === 1'b1) wr_q.push_back({dm_waddr, dm_wdata});
      if (pm_data_rd === 1'b1) rd_addr <= pm_data_addr;
      if (wreg === 8'h41 && status[2] === 1'b1) z_hold <= 1'b1;
      if (wreg === 8'hEE) annul_w <= 1'b1;
      if (status[7:5] === 3'h3) page3 <= 1'b1;
      if (pm_addr === 16'h0040) in_sub <= 1'b1;
      if (pm_addr === 16'h001B && in_sub) back <= 1'b1;
      if (pm_addr === 16'h2005) far <= 1'b1;
      if (wreg === 8'hBE) got_rd <= 1'b1;
      if (pm_addr === 16'h20A0) rel_jmp <= 1'b1;
    end
  end
  // Generous bound: the program settles within a few hundred cycles
  initial begin
    #(2000 * 8);
    err_count++;
    finish_test;
  end
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    @(posedge clock);
    foreach (prog[i]) mem.pm[prog[i][31:16]] = prog[i][15:0];
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    n = 0;
    while (pm_addr !== 16'h20A0 && n < 400) begin
      @(posedge clock);
      n++;
    end
    check("program end reached", 20'h0, {19'h0, n >= 400});
    repeat (20) @(posedge clock);
    check("write count", 20'd5, 20'(wr_q.size()));
    foreach (exp_w[i]) check("memory write", exp_w[i], (i < wr_q.size()) ? wr_q[i] : 20'hFFFFF);
    check("compare keeps w, sets zero", 20'h1, {19'h0, z_hold});
    check("annulled move", 20'h0, {19'h0, annul_w});
    check("annulled page", 20'h0, {19'h0, page3});
    check("return to caller", 20'h1, {19'h0, back});
    check("paged jump target", 20'h1, {19'h0, far});
    check("relative jump via low alias", 20'h1, {19'h0, rel_jmp});
    check("page bits", 20'h1, {17'h0, status[7:5]});
    check("read pointer", 20'h01234, {4'h0, rd_addr});
    check("read word high", 20'h1, {19'h0, got_rd});
    // Pause longer than the three-cycle loop, so a running fetch would show
    ce <= 1'b0;
    @(posedge clock);
    pc_hold = pm_addr;
    repeat (4) @(posedge clock);
    check("enable low freezes fetch", {4'h0, pc_hold}, {4'h0, pm_addr});
    ce <= 1'b1;
    repeat (20) @(posedge clock);
    check("loop after pause", 20'h1, {19'h0, pm_addr >= 16'h20A0 && pm_addr <= 16'h20A2});
    check("final w", 20'h00099, {12'h0, wreg});
    finish_test;
  end
endmodule
